// ### hw/wwd_watchdog.sv
// How it works
// - timeout grows piecewise with the low six counter bits
// - timebase select picks coarse and fine constants from a table
// - minimum timeout piecewise, swapping 16384 steps per quotient
// - maximum timeout same form, simple branch up to coarse over four
// - all divisions truncate downward
// - slow and wait modes do not change the decrement rate
// - plain halt: one decrement, then counter frozen, no reset
// - interrupt wake from halt resumes after 256 or 4096 clocks
// - reset ending halt disables watchdog unless hardware option
// - halt with reset-on-halt option, active watchdog and no rtc irq resets
// - rtc irq enabled: halt enters active-halt, counter stops
// - interrupt wake from active-halt resumes counting immediately
// - reset wake from active-halt resumes after 256 or 4096 clocks
// - hardware option keeps watchdog always active
// - counter decrements every 16384 cycles, even when disabled
// - active watchdog resets when counter goes 40h to 3Fh
// - reload only legal below window and above 3Fh
// - software mode: off after reset, set once, cleared by reset
module wwd_watchdog
  import wwd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire wwd_option_type option,
  input wire wwd_power_type power,
  input wire logic rtcIrqEnable,
  input wire logic [1:0] timebaseSelect,
  input wire logic controlWrite,
  input wire logic [7:0] controlData,
  input wire logic windowWrite,
  input wire logic [6:0] windowData,
  output logic [7:0] wdControlReg,
  output logic [6:0] wdWindowReg,
  output logic wdResetReq,
  output logic counterRunning,
  output logic [23:0] minTimeoutCycles,
  output logic [23:0] maxTimeoutCycles
);

  logic rstSync1_reg;
  logic rstSync2_reg;
  logic rstN;

  logic [13:0] prescale_reg;
  logic [13:0] prescale_next;
  logic tick;

  logic [6:0] counter_reg;
  logic [6:0] counter_next;
  logic activate_reg;
  logic activate_next;
  logic [6:0] window_reg;
  logic [6:0] window_next;
  logic resetReq_reg;
  logic resetReq_next;
  wwd_state_type state_reg;
  wwd_state_type state_next;
  logic [12:0] wake_reg;
  logic [12:0] wake_next;
  logic haltDecPend_reg;
  logic haltDecPend_next;

  logic active;
  logic counting;

  function automatic logic [12:0] wakeLoad(input wwd_option_type opt);
    return opt.longWakeDelay ? WAKE_LONG_CNT : WAKE_SHORT_CNT;
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  assign rstN = rstSync2_reg;

  // free-running prescaler, never touched by register writes
  always_comb begin
    prescale_next = prescale_reg + 14'h0001;
  end
  assign tick = (prescale_reg == PRESCALE_LAST);

  assign active = activate_reg | option.hwWatchdog;
  assign counting = (state_reg == WWD_RUN) | haltDecPend_reg;

  always_comb begin
    counter_next = counter_reg;
    activate_next = activate_reg;
    window_next = window_reg;
    resetReq_next = resetReq_reg;
    state_next = state_reg;
    wake_next = wake_reg;
    haltDecPend_next = haltDecPend_reg;

    if (windowWrite) begin
      window_next = windowData;
    end

    if (tick && counting) begin
      counter_next = counter_reg - 7'h01;
      haltDecPend_next = 1'b0;
      if (active && (state_reg == WWD_RUN) && (counter_reg == CNT_TOP_VAL)) begin
        resetReq_next = 1'b1;
      end
    end

    if (controlWrite) begin
      counter_next = controlData[TOP_BIT:0];
      if (controlData[7]) begin
        activate_next = 1'b1;
      end
      if (active || controlData[7]) begin
        if (!controlData[TOP_BIT]) begin
          resetReq_next = 1'b1;
        end
        if (active && ((counter_reg >= window_reg) || (counter_reg <= CNT_FLOOR))) begin
          resetReq_next = 1'b1;
        end
      end
    end

    case (state_reg)
      WWD_RUN: begin
        if (power.haltExec) begin
          if (rtcIrqEnable) begin
            state_next = WWD_ACT_HALT;
          end else if (option.resetOnHaltOption && active) begin
            resetReq_next = 1'b1;
          end else begin
            state_next = WWD_HALTED;
            haltDecPend_next = 1'b1;
          end
        end
      end
      WWD_HALTED: begin
        if (power.wakeReset) begin
          state_next = WWD_WAKE_WAIT;
          haltDecPend_next = 1'b0;
          wake_next = wakeLoad(option);
          if (!option.hwWatchdog) begin
            activate_next = 1'b0;
          end
        end else if (power.wakeIrq) begin
          state_next = WWD_WAKE_WAIT;
          haltDecPend_next = 1'b0;
          wake_next = wakeLoad(option);
        end
      end
      WWD_ACT_HALT: begin
        if (power.wakeReset) begin
          state_next = WWD_WAKE_WAIT;
          wake_next = wakeLoad(option);
          if (!option.hwWatchdog) begin
            activate_next = 1'b0;
          end
        end else if (power.wakeIrq) begin
          state_next = WWD_RUN;
        end
      end
      WWD_WAKE_WAIT: begin
        wake_next = wake_reg - 13'h0001;
        if (wake_reg == 13'h0001) begin
          state_next = WWD_RUN;
        end
      end
      default: begin
        state_next = WWD_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      prescale_reg <= 14'h0000;
      counter_reg <= CNT_RESET;
      activate_reg <= 1'b0;
      window_reg <= WIN_RESET;
      resetReq_reg <= 1'b0;
      state_reg <= WWD_RUN;
      wake_reg <= 13'h0000;
      haltDecPend_reg <= 1'b0;
    end else begin
      prescale_reg <= prescale_next;
      counter_reg <= counter_next;
      activate_reg <= activate_next;
      window_reg <= window_next;
      resetReq_reg <= resetReq_next;
      state_reg <= state_next;
      wake_reg <= wake_next;
      haltDecPend_reg <= haltDecPend_next;
    end
  end

  assign wdControlReg = {activate_reg, counter_reg};
  assign wdWindowReg = window_reg;
  assign wdResetReq = resetReq_reg;
  assign counterRunning = counting;

  wwd_timeout_calc calc (
    .timeoutCount(counter_reg[5:0]),
    .timebaseSelect(timebaseSelect),
    .minCycles(minTimeoutCycles),
    .maxCycles(maxTimeoutCycles)
  );

endmodule

// ### hw/wwd_pkg.sv
package wwd_pkg;

  // counter field layout
  localparam int CNT_WIDTH = 7;
  localparam int TOP_BIT = 6;
  localparam logic [6:0] CNT_RESET = 7'h7f;
  localparam logic [6:0] WIN_RESET = 7'h7f;
  localparam logic [6:0] CNT_FLOOR = 7'h3f;
  localparam logic [6:0] CNT_TOP_VAL = 7'h40;

  // clock and prescaler
  localparam int REF_CLK_HZ = 10_000_000;
  localparam int PRESCALE_CYCLES = 16384;
  localparam logic [13:0] PRESCALE_LAST = 14'h3fff;

  // wake-up restart delays in cpu clocks
  localparam int WAKE_SHORT_CLOCKS = 256;
  localparam int WAKE_LONG_CLOCKS = 4096;
  localparam logic [12:0] WAKE_SHORT_CNT = 13'h0100;
  localparam logic [12:0] WAKE_LONG_CNT = 13'h1000;

  // timeout formula constants
  localparam int TMIN_OFFSET = 128;
  localparam int STEP_OFFSET = 192;
  localparam int SUB_CYCLES = 64;

  typedef enum logic [1:0] {
    WWD_RUN = 2'b00,
    WWD_HALTED = 2'b01,
    WWD_ACT_HALT = 2'b10,
    WWD_WAKE_WAIT = 2'b11
  } wwd_state_type;

  // option byte settings
  typedef struct packed {
    logic hwWatchdog;
    logic resetOnHaltOption;
    logic longWakeDelay;
  } wwd_option_type;

  // cpu power events, one-cycle pulses
  typedef struct packed {
    logic haltExec;
    logic wakeIrq;
    logic wakeReset;
  } wwd_power_type;

  typedef struct packed {
    logic [5:0] msb;
    logic [5:0] lsb;
  } wwd_timebase_type;

  function automatic wwd_timebase_type wwd_timebase(input logic [1:0] sel);
    wwd_timebase_type t;
    t = '{msb: 6'h04, lsb: 6'h3b};
    case (sel)
      2'b00: t = '{msb: 6'h04, lsb: 6'h3b};
      2'b01: t = '{msb: 6'h08, lsb: 6'h35};
      2'b10: t = '{msb: 6'h14, lsb: 6'h23};
      2'b11: t = '{msb: 6'h31, lsb: 6'h36};
      default: t = '{msb: 6'h04, lsb: 6'h3b};
    endcase
    return t;
  endfunction

endpackage

// ### hw/wwd_timeout_calc.sv
module wwd_timeout_calc
  import wwd_pkg::*;
(
  input wire logic [5:0] timeoutCount,
  input wire logic [1:0] timebaseSelect,
  output logic [23:0] minCycles,
  output logic [23:0] maxCycles
);

  wwd_timebase_type tb;
  logic [5:0] msbQuarter;
  logic [7:0] quot;
  logic [23:0] stepPart;
  logic [23:0] minBase;

  always_comb begin
    tb = wwd_timebase(timebaseSelect);
    msbQuarter = {2'b00, tb.msb[5:2]};
    quot = 8'({timeoutCount, 2'b00} / tb.msb);
    minBase = 24'((tb.lsb + TMIN_OFFSET) * SUB_CYCLES);
    stepPart = 24'(PRESCALE_CYCLES * (timeoutCount - quot)) +
      24'((STEP_OFFSET + tb.lsb) * SUB_CYCLES * quot);
    if (timeoutCount < msbQuarter) begin
      minCycles = minBase + 24'(PRESCALE_CYCLES * timeoutCount);
    end else begin
      minCycles = minBase + stepPart;
    end
    if (timeoutCount <= msbQuarter) begin
      maxCycles = 24'(PRESCALE_CYCLES) + 24'(PRESCALE_CYCLES * timeoutCount);
    end else begin
      maxCycles = 24'(PRESCALE_CYCLES) + stepPart;
    end
  end

endmodule

// ### tb/wwd_watchdog_assertions.sv
module wwd_watchdog_assertions
  import wwd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire wwd_option_type option,
  input wire wwd_power_type power,
  input wire logic rtcIrqEnable,
  input wire logic controlWrite,
  input wire logic [7:0] controlData,
  input wire logic windowWrite,
  input wire logic [6:0] windowData,
  input wire logic [7:0] wdControlReg,
  input wire logic [6:0] wdWindowReg,
  input wire logic wdResetReq,
  input wire logic counterRunning
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act;
  assign act = wdControlReg[7] | option.hwWatchdog;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  top_bit_a: assert property (controlWrite && act && !controlData[6] |=> wdResetReq)
    else $error("write with top bit clear gave no reset");
  window_check_a: assert property (controlWrite && act &&
    (wdControlReg[6:0] >= wdWindowReg || !wdControlReg[6]) |=> wdResetReq)
    else $error("reload outside window gave no reset");
  window_load_a: assert property (windowWrite |=> wdWindowReg == $past(windowData))
    else $error("window value not loaded");
  roll_over_a: assert property (act && !controlWrite && wdControlReg[6:0] == CNT_TOP_VAL
    ##1 wdControlReg[6:0] == CNT_FLOOR && counterRunning |-> wdResetReq)
    else $error("roll to 3f gave no reset");
  halt_reset_a: assert property (power.haltExec && act && !rtcIrqEnable &&
    option.resetOnHaltOption |=> wdResetReq) else $error("halt gave no reset");
  active_halt_a: assert property (power.haltExec && rtcIrqEnable && !controlWrite
    |=> !counterRunning && $stable(wdResetReq)) else $error("active halt did not freeze");
  dec_step_a: assert property (!$past(controlWrite) && $changed(wdControlReg[6:0])
    |-> wdControlReg[6:0] == $past(wdControlReg[6:0]) - 7'h01) else $error("bad count step");
  act_keep_a: assert property (wdControlReg[7] && !power.wakeReset |=> wdControlReg[7])
    else $error("activation bit cleared");
  cover property (power.wakeIrq);
  cover property ($rose(wdResetReq));
  cover property (power.haltExec && rtcIrqEnable);
endmodule

// ### tb/testbench.sv
module testbench
  import wwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, reset_n = 0, rtcIrqEnable = 0, controlWrite = 0, windowWrite = 0;
  logic [1:0] timebaseSelect = '0;
  logic [7:0] controlData = '0, wdControlReg;
  logic [6:0] windowData = '0, wdWindowReg;
  logic wdResetReq, counterRunning;
  logic [23:0] minT, maxT;
  wwd_option_type opt = '0;
  wwd_power_type pwr = '0;
  int error_cnt = 0, total_checks = 0, n, s, c;
  logic [31:0] seed = 32'haf4865a9, r;
  int msbT[4] = '{4, 8, 20, 49};
  int lsbT[4] = '{59, 53, 35, 54};
  logic [7:0] bad[2] = '{8'h80, 8'hff};
  always #50 ref_clk = ~ref_clk;
  wwd_watchdog u_dut(.ref_clk(ref_clk), .reset_n(reset_n), .option(opt), .power(pwr),
    .rtcIrqEnable(rtcIrqEnable), .timebaseSelect(timebaseSelect),
    .controlWrite(controlWrite), .controlData(controlData), .windowWrite(windowWrite),
    .windowData(windowData), .wdControlReg(wdControlReg), .wdWindowReg(wdWindowReg),
    .wdResetReq(wdResetReq), .counterRunning(counterRunning), .minTimeoutCycles(minT),
    .maxTimeoutCycles(maxT));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [23:0] tcalc(input int c, input int s, input bit mx);
    int m = msbT[s];
    int l = lsbT[s];
    int q = 4 * c / m;
    int b = mx ? 16384 : (l + 128) * 64;
    if (mx ? c <= m / 4 : c < m / 4) return 24'(b + 16384 * c);
    return 24'(b + 16384 * (c - q) + (192 + l) * 64 * q);
  endfunction
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rst();
    reset_n <= 0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wr(input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    controlWrite <= !w;
    windowWrite <= w;
    controlData <= d;
    windowData <= d[6:0];
    @(posedge ref_clk);
    controlWrite <= 0;
    windowWrite <= 0;
    #1;
  endtask
  task automatic pulse(input wwd_power_type p);
    @(posedge ref_clk);
    pwr <= p;
    @(posedge ref_clk);
    pwr <= '0;
    #1;
  endtask
  task automatic waitc();
    logic [6:0] v;
    v = wdControlReg[6:0];
    n = 0;
    while (wdControlReg[6:0] === v && n < 16400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  initial begin
    rst();
    check("control", 24'(wdControlReg), 24'h7f);
    check("window", 24'(wdWindowReg), 24'h7f);
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      s = i < 12 ? i % 4 : int'(r[9:8]);
      c = i < 4 ? 0 : i < 8 ? 63 : i < 12 ? msbT[s] / 4 : int'(r[5:0]);
      @(posedge ref_clk);
      timebaseSelect <= 2'(s);
      wr(0, {2'b01, 6'(c)});
      check("count", 24'(wdControlReg), 24'({2'b01, 6'(c)}));
      check("tmin", minT, tcalc(c, s, 0));
      check("tmax", maxT, tcalc(c, s, 1));
    end
    wr(0, 8'h7f);
    waitc();
    waitc();
    check("period", 24'(n), 24'd16384);
    check("step", 24'(wdControlReg), 24'h7d);
    wr(1, 8'h7f);
    wr(0, 8'hc0);
    check("legal", 24'(wdResetReq), 24'h0);
    waitc();
    check("expiry", 24'(wdResetReq), 24'h1);
    check("prescale", 24'(n), 24'd16380);
    rst();
    opt <= 3'b110;
    pulse(3'b100);
    check("haltreset", 24'(wdResetReq), 24'h1);
    foreach (bad[j]) begin
      rst();
      wr(0, bad[j]);
      check("badwrite", 24'(wdResetReq), 24'h1);
    end
    for (int k = 0; k < 3; k++) begin
      rst();
      opt <= {1'(k == 1), 1'b0, 1'(k == 1)};
      rtcIrqEnable <= 1'(k == 1);
      if (k != 1) wr(0, 8'hff);
      pulse(3'b100);
      if (k == 1) check("frozen", 24'(counterRunning), 24'h0);
      pulse(k == 0 ? 3'b010 : 3'b001);
      repeat ((k == 1 ? 4096 : 256) - 8) @(posedge ref_clk);
      #1;
      check("delay", 24'(counterRunning), 24'h0);
      n = 0;
      while (counterRunning !== 1'b1 && n < 20) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      check("wakecnt", 24'(n), 24'd8);
      check("resume", 24'(counterRunning), 24'h1);
      check("noreset", 24'(wdResetReq), 24'h0);
      check("activate", 24'(wdControlReg[7]), 24'(k == 0));
    end
    rtcIrqEnable <= 1'b1;
    pulse(3'b100);
    pulse(3'b010);
    check("quick", 24'(counterRunning), 24'h1);
    final_report();
  end
  initial begin
    #(100 * 90000);
    error_cnt++;
    final_report();
  end
endmodule
bind wwd_watchdog wwd_watchdog_assertions u_chk(.ref_clk(ref_clk), .reset_n(reset_n),
  .option(option), .power(power), .rtcIrqEnable(rtcIrqEnable), .controlWrite(controlWrite),
  .controlData(controlData), .windowWrite(windowWrite), .windowData(windowData),
  .wdControlReg(wdControlReg), .wdWindowReg(wdWindowReg), .wdResetReq(wdResetReq),
  .counterRunning(counterRunning));
